// ===== design/freq_time_tagger.sv
// dual input frequency counter with inter-edge timeout and time tag buffer
// assumes classic wishbone master on clock; sig_in pins are asynchronous
//
// Summary of operation
// - two independent input configurations; index 0 front, index 1 rear
// - per input edge polarity selectable; rising after defaults
// - sample count per measurement programmable 1 to 1e9, default one
// - gate interval programmable from 10 ms to 1000 s
// - defaults set gate interval to 0.1 s
// - timeout programmable from 10 ms to 2000 s
// - defaults set timeout to 1.0 s
// - timeout when gap between qualifying edges exceeds timeout; gate ignored
// - timed out sample reports nan code, then next sample continues
// - with steady input each sample lasts about the gate interval
// - tag buffer holds at most 250000 tags; policy rules overflow
// - keep_oldest drops new tags while full
// - keep_newest discards oldest tag when full, keeps new one
// - defaults set overflow policy to keep_newest
// - in keep_oldest, reading tags frees space for new tags
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module freq_time_tagger #(
    parameter int DEPTH = tagger_pkg::TAG_DEPTH,
    parameter int TAG_W = 32,
    parameter int CYC_MS = int'(tagger_pkg::CYC_PER_MS)
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // signal inputs, front then rear
    input wire logic [1:0] sig_in,
    // interrupt
    output logic irq_o
);
    localparam int AW = $clog2(DEPTH);
    // time limits in system clock cycles; CYC_MS is cycles per millisecond
    localparam logic [47:0] GATE_MIN = 48'(tagger_pkg::GATE_MIN_MS * CYC_MS);
    localparam logic [47:0] GATE_MAX = 48'(tagger_pkg::GATE_MAX_MS * CYC_MS);
    localparam logic [47:0] GATE_DEF = 48'(tagger_pkg::GATE_DEF_MS * CYC_MS);
    localparam logic [47:0] TMO_MIN = 48'(tagger_pkg::TMO_MIN_MS * CYC_MS);
    localparam logic [47:0] TMO_MAX = 48'(tagger_pkg::TMO_MAX_MS * CYC_MS);
    localparam logic [47:0] TMO_DEF = 48'(tagger_pkg::TMO_DEF_MS * CYC_MS);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detect
    logic [1:0] sync1_ff, sync2_ff, last_ff;
    tagger_pkg::chan_cfg_t cfg_ff [2];
    logic [1:0] qual_edge;
    // no reset: the chain fills during reset, so no false edge after it
    always_ff @(posedge clock) begin
        sync1_ff <= sig_in;
        sync2_ff <= sync1_ff;
        last_ff <= sync2_ff;
    end
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            qual_edge[c] = cfg_ff[c].falling ?
                (last_ff[c] & ~sync2_ff[c]) :
                (~last_ff[c] & sync2_ff[c]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic bus_req, wr_req;
    logic ack_ff;
    logic [31:0] rdata_ff;
    assign bus_req = cyc_i & stb_i & ~ack_ff;
    assign wr_req = bus_req & we_i & (&sel_i);

    function automatic logic [47:0] clamp48(input logic [47:0] v,
            input logic [47:0] lo, input logic [47:0] hi);
        clamp48 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp48

    function automatic logic chan_hit(input logic [7:0] a, input int c,
            input logic [7:0] off);
        chan_hit = (a == 8'(c * tagger_pkg::CH_STRIDE + off));
    endfunction : chan_hit

    ////////////////////////////////////////////////////////////////////////
    // per channel configuration and measurement
    logic [1:0] busy_ff, start_req, dflt_req;
    logic [47:0] gate_cnt_ff [2];
    logic [47:0] tmo_cnt_ff [2];
    logic [31:0] edges_ff [2];
    logic [31:0] result_ff [2];
    logic [29:0] done_ff [2];
    logic [1:0] armed_ff;
    tagger_pkg::chan_evt_t evt [2];
    logic [1:0] tag_push;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            start_req[c] = wr_req &
                chan_hit(adr_i, c, tagger_pkg::OFF_CTRL) &
                dat_i[tagger_pkg::CTRL_START];
            dflt_req[c] = wr_req &
                chan_hit(adr_i, c, tagger_pkg::OFF_CTRL) &
                dat_i[tagger_pkg::CTRL_DEFAULTS];
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_chan
        // configuration
        always_ff @(posedge clock) begin
            if (!reset_n || dflt_req[c]) begin
                cfg_ff[c].falling <= 1'b0;
                cfg_ff[c].count <= tagger_pkg::COUNT_DEF;
                cfg_ff[c].gate <= GATE_DEF;
                cfg_ff[c].timeout <= TMO_DEF;
            end else if (wr_req) begin
                if (chan_hit(adr_i, c, tagger_pkg::OFF_CTRL))
                    cfg_ff[c].falling <= dat_i[tagger_pkg::CTRL_FALLING];
                if (chan_hit(adr_i, c, tagger_pkg::OFF_COUNT))
                    cfg_ff[c].count <= (dat_i[29:0] == 30'h0) ?
                        tagger_pkg::COUNT_MIN :
                        ((dat_i[29:0] > tagger_pkg::COUNT_MAX) ?
                        tagger_pkg::COUNT_MAX : dat_i[29:0]);
                if (chan_hit(adr_i, c, tagger_pkg::OFF_GATE))
                    cfg_ff[c].gate <= clamp48({dat_i, 16'h0000},
                        GATE_MIN, GATE_MAX);
                if (chan_hit(adr_i, c, tagger_pkg::OFF_TMO))
                    cfg_ff[c].timeout <= clamp48({dat_i, 16'h0000},
                        TMO_MIN, TMO_MAX);
            end
        end

        // sample sequencing
        always_comb begin
            evt[c].timed_out = busy_ff[c] &&
                tmo_cnt_ff[c] >= cfg_ff[c].timeout;
            evt[c].sample = busy_ff[c] && !evt[c].timed_out &&
                gate_cnt_ff[c] >= cfg_ff[c].gate;
        end
        assign tag_push[c] = busy_ff[c] & qual_edge[c];

        always_ff @(posedge clock) begin
            if (!reset_n) begin
                busy_ff[c] <= 1'b0;
                armed_ff[c] <= 1'b0;
                gate_cnt_ff[c] <= 48'h0;
                tmo_cnt_ff[c] <= 48'h0;
                edges_ff[c] <= 32'h0;
                result_ff[c] <= 32'h0;
                done_ff[c] <= 30'h0;
            end else if (start_req[c]) begin
                busy_ff[c] <= 1'b1;
                armed_ff[c] <= 1'b0;
                gate_cnt_ff[c] <= 48'h0;
                tmo_cnt_ff[c] <= 48'h0;
                edges_ff[c] <= 32'h0;
                done_ff[c] <= 30'h0;
            end else if (busy_ff[c]) begin
                if (evt[c].timed_out || evt[c].sample) begin
                    result_ff[c] <= evt[c].timed_out ?
                        tagger_pkg::NAN_VALUE : edges_ff[c];
                    done_ff[c] <= done_ff[c] + 30'h1;
                    busy_ff[c] <= (done_ff[c] + 30'h1) != cfg_ff[c].count;
                    gate_cnt_ff[c] <= 48'h0;
                    tmo_cnt_ff[c] <= 48'h0;
                    edges_ff[c] <= 32'h0;
                end else begin
                    if (qual_edge[c]) begin
                        armed_ff[c] <= 1'b1;
                        tmo_cnt_ff[c] <= 48'h0;
                        if (armed_ff[c])
                            edges_ff[c] <= edges_ff[c] + 32'h1;
                    end else begin
                        tmo_cnt_ff[c] <= tmo_cnt_ff[c] + 48'h1;
                    end
                    if (armed_ff[c] || qual_edge[c])
                        gate_cnt_ff[c] <= gate_cnt_ff[c] + 48'h1;
                end
            end
        end

        chk_nan_on_timeout: assert property (@(posedge clock)
            disable iff (!reset_n)
            evt[c].timed_out && !start_req[c] |=>
                result_ff[c] == tagger_pkg::NAN_VALUE)
            else $error("timeout did not report nan");
        chk_edge_restart: assert property (@(posedge clock)
            disable iff (!reset_n)
            busy_ff[c] && qual_edge[c] && !start_req[c] |=>
                tmo_cnt_ff[c] == 48'h0)
            else $error("timeout counter not restarted");
        chk_gate_ignored: assert property (@(posedge clock)
            disable iff (!reset_n)
            busy_ff[c] && !evt[c].timed_out && !evt[c].sample &&
            !qual_edge[c] && !start_req[c] && !wr_req &&
            tmo_cnt_ff[c] == cfg_ff[c].timeout - 48'h1 |=>
                evt[c].timed_out)
            else $error("timeout missed while gate still open");
        chk_set_continues: assert property (@(posedge clock)
            disable iff (!reset_n)
            evt[c].timed_out && !start_req[c] &&
            (done_ff[c] + 30'h1) != cfg_ff[c].count |=> busy_ff[c])
            else $error("set stopped after timeout");
        chk_gate_bounds: assert property (@(posedge clock)
            disable iff (!reset_n)
            cfg_ff[c].gate >= GATE_MIN &&
            cfg_ff[c].gate <= GATE_MAX)
            else $error("gate out of range");
        chk_tmo_bounds: assert property (@(posedge clock)
            disable iff (!reset_n)
            cfg_ff[c].timeout >= TMO_MIN &&
            cfg_ff[c].timeout <= TMO_MAX)
            else $error("timeout out of range");
        chk_count_bounds: assert property (@(posedge clock)
            disable iff (!reset_n)
            cfg_ff[c].count >= tagger_pkg::COUNT_MIN &&
            cfg_ff[c].count <= tagger_pkg::COUNT_MAX)
            else $error("count out of range");
        chk_defaults: assert property (@(posedge clock)
            disable iff (!reset_n)
            dflt_req[c] |=> cfg_ff[c].gate == GATE_DEF &&
                cfg_ff[c].timeout == TMO_DEF &&
                !cfg_ff[c].falling)
            else $error("defaults not applied");
        chk_count_default: assert property (@(posedge clock)
            disable iff (!reset_n)
            dflt_req[c] |=> cfg_ff[c].count == 30'h0000_0001)
            else $error("default sample count not one");
    end

    ////////////////////////////////////////////////////////////////////////
    // time tag buffer
    logic [TAG_W-1:0] tag_mem [DEPTH];
    logic [AW-1:0] wptr_ff, rptr_ff;
    logic [AW:0] level_ff;
    logic [TAG_W-1:0] tstamp_ff;
    logic policy_ff;
    logic push, pop, full, empty, drop_new, drop_old;
    logic [TAG_W-1:0] push_val;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    assign push = |tag_push;
    assign push_val = tstamp_ff;
    assign full = level_ff == (AW + 1)'(DEPTH);
    assign empty = level_ff == '0;
    assign pop = bus_req & ~we_i & (adr_i == tagger_pkg::OFF_TAG) & ~empty;
    assign drop_new = push & full & ~pop &
        (policy_ff == tagger_pkg::keep_oldest);
    assign drop_old = push & full & ~pop &
        (policy_ff == tagger_pkg::keep_newest);

    always_ff @(posedge clock) begin
        if (!reset_n)
            tstamp_ff <= '0;
        else
            tstamp_ff <= tstamp_ff + TAG_W'(1);
    end

    always_ff @(posedge clock) begin
        if (!reset_n || (wr_req && adr_i == tagger_pkg::OFF_GLOBAL &&
                dat_i[tagger_pkg::CTRL_DEFAULTS]))
            policy_ff <= tagger_pkg::GLB_POLICY_DEF;
        else if (wr_req && adr_i == tagger_pkg::OFF_GLOBAL)
            policy_ff <= dat_i[tagger_pkg::GLB_POLICY];
    end

    always_ff @(posedge clock) begin
        if (push && !drop_new)
            tag_mem[wptr_ff] <= push_val;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            level_ff <= '0;
        end else begin
            if (push && !drop_new)
                wptr_ff <= ptr_inc(wptr_ff);
            if (pop || drop_old)
                rptr_ff <= ptr_inc(rptr_ff);
            case ({push && !drop_new && !drop_old, pop})
                2'b10: level_ff <= level_ff + (AW + 1)'(1);
                2'b01: level_ff <= level_ff - (AW + 1)'(1);
                default: level_ff <= level_ff;
            endcase
        end
    end

    chk_level_cap: assert property (@(posedge clock) disable iff (!reset_n)
        level_ff <= (AW + 1)'(DEPTH))
        else $error("tag buffer over capacity");
    chk_oldest_drop: assert property (@(posedge clock) disable iff (!reset_n)
        drop_new |=> wptr_ff == $past(wptr_ff) && full)
        else $error("keep_oldest stored a tag while full");
    chk_newest_keep: assert property (@(posedge clock) disable iff (!reset_n)
        drop_old |=> wptr_ff != $past(wptr_ff) && full)
        else $error("keep_newest did not replace oldest");
    chk_pop_frees: assert property (@(posedge clock) disable iff (!reset_n)
        pop && !push |=> level_ff == $past(level_ff) - (AW + 1)'(1))
        else $error("read did not free an entry");
    chk_policy_default: assert property (@(posedge clock)
        disable iff (!reset_n)
        wr_req && adr_i == tagger_pkg::OFF_GLOBAL &&
        dat_i[tagger_pkg::CTRL_DEFAULTS] |=>
            policy_ff == tagger_pkg::keep_newest)
        else $error("overflow policy default not keep_newest");

    ////////////////////////////////////////////////////////////////////////
    // interrupts
    logic [tagger_pkg::IRQ_W-1:0] irq_stat_ff, irq_mask_ff, irq_set;
    assign irq_set = {drop_new | drop_old, evt[1].timed_out,
        evt[0].timed_out, evt[1].sample | evt[1].timed_out,
        evt[0].sample | evt[0].timed_out};
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_req && adr_i == tagger_pkg::OFF_IRQ_STAT)
                irq_stat_ff <= (irq_stat_ff &
                    ~dat_i[tagger_pkg::IRQ_W-1:0]) | irq_set;
            else
                irq_stat_ff <= irq_stat_ff | irq_set;
            if (wr_req && adr_i == tagger_pkg::OFF_IRQ_MASK)
                irq_mask_ff <= dat_i[tagger_pkg::IRQ_W-1:0];
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux and ack
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        for (int c = 0; c < 2; c++) begin
            if (chan_hit(adr_i, c, tagger_pkg::OFF_CTRL))
                rd_val = {23'h0, busy_ff[c], 7'h0, cfg_ff[c].falling};
            if (chan_hit(adr_i, c, tagger_pkg::OFF_COUNT))
                rd_val = {2'h0, cfg_ff[c].count};
            if (chan_hit(adr_i, c, tagger_pkg::OFF_GATE))
                rd_val = cfg_ff[c].gate[47:16];
            if (chan_hit(adr_i, c, tagger_pkg::OFF_TMO))
                rd_val = cfg_ff[c].timeout[47:16];
            if (chan_hit(adr_i, c, tagger_pkg::OFF_RESULT))
                rd_val = result_ff[c];
            if (chan_hit(adr_i, c, tagger_pkg::OFF_DONE))
                rd_val = {2'h0, done_ff[c]};
        end
        case (adr_i)
            tagger_pkg::OFF_TAG: rd_val = empty ? 32'h0 : 32'(tag_mem[rptr_ff]);
            tagger_pkg::OFF_LEVEL: rd_val = 32'(level_ff);
            tagger_pkg::OFF_IRQ_STAT: rd_val = 32'(irq_stat_ff);
            tagger_pkg::OFF_IRQ_MASK: rd_val = 32'(irq_mask_ff);
            tagger_pkg::OFF_GLOBAL: rd_val = {31'h0, policy_ff};
            default: rd_val = rd_val;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= bus_req;
            rdata_ff <= rd_val;
        end
    end
    assign ack_o = ack_ff;
    assign dat_o = rdata_ff;
endmodule : freq_time_tagger

// ===== design/tagger_pkg.sv
// package: register map, field layouts, timing constants for the tagger
// assumes a 100 MHz system clock and classic wishbone register access
package tagger_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // times in milliseconds
    localparam longint unsigned GATE_MIN_MS = 10;
    localparam longint unsigned GATE_MAX_MS = 1_000_000;
    localparam longint unsigned GATE_DEF_MS = 100;
    localparam longint unsigned TMO_MIN_MS = 10;
    localparam longint unsigned TMO_MAX_MS = 2_000_000;
    localparam longint unsigned TMO_DEF_MS = 1000;
    localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam logic [47:0] GATE_MIN_CYC = 48'(GATE_MIN_MS * CYC_PER_MS);
    localparam logic [47:0] GATE_MAX_CYC = 48'(GATE_MAX_MS * CYC_PER_MS);
    localparam logic [47:0] GATE_DEF_CYC = 48'(GATE_DEF_MS * CYC_PER_MS);
    localparam logic [47:0] TMO_MIN_CYC = 48'(TMO_MIN_MS * CYC_PER_MS);
    localparam logic [47:0] TMO_MAX_CYC = 48'(TMO_MAX_MS * CYC_PER_MS);
    localparam logic [47:0] TMO_DEF_CYC = 48'(TMO_DEF_MS * CYC_PER_MS);
    localparam logic [29:0] COUNT_MIN = 30'h0000_0001;
    localparam logic [29:0] COUNT_MAX = 30'h3b9a_ca00;
    localparam logic [29:0] COUNT_DEF = 30'h0000_0001;
    localparam logic [31:0] NAN_VALUE = 32'h7f6e_ec30;
    localparam int unsigned TAG_DEPTH = 250_000;
    // register byte offsets; channel block stride
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_GATE = 8'h08;
    localparam logic [7:0] OFF_TMO = 8'h0c;
    localparam logic [7:0] OFF_RESULT = 8'h10;
    localparam logic [7:0] OFF_DONE = 8'h14;
    localparam logic [7:0] OFF_TAG = 8'h40;
    localparam logic [7:0] OFF_LEVEL = 8'h44;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h48;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h4c;
    localparam logic [7:0] OFF_GLOBAL = 8'h50;
    // ctrl fields
    localparam int CTRL_FALLING = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_DEFAULTS = 2;
    localparam int CTRL_BUSY = 8;
    // global fields
    localparam int GLB_POLICY = 0;
    localparam logic GLB_POLICY_DEF = 1'b1;
    // irq status bits
    localparam int IRQ_W = 5;
    localparam int IRQ_SAMPLE = 0;
    localparam int IRQ_TIMEOUT = 2;
    localparam int IRQ_DROP = 4;
    typedef enum logic {keep_oldest = 1'b0, keep_newest = 1'b1} overflow_policy_t;
    typedef struct packed {
        logic falling;
        logic [29:0] count;
        logic [47:0] gate;
        logic [47:0] timeout;
    } chan_cfg_t;
    typedef struct packed {
        logic sample;
        logic timed_out;
    } chan_evt_t;
endpackage : tagger_pkg

// ===== sim/sig_source.sv
// partner: signal generator on the front and rear measurement inputs
// assumes the bench calls its tasks; pins move right after clock edges
`timescale 1ns/1ns
module sig_source (
    // clock
    input wire logic clock,
    // pins, front then rear
    output logic [1:0] pins
);
    // front idles high so its first falling edge can be made at will
    initial pins = 2'b01;

    task automatic set_pin(input int ch, input logic v);
        @(posedge clock);
        pins[ch] <= v;
    endtask : set_pin

    // one rising edge; the next one may follow gap cycles later
    task automatic pulse(input int ch, input int gap);
        set_pin(ch, 1'b1);
        repeat (gap / 2 - 1) @(posedge clock);
        set_pin(ch, 1'b0);
        repeat (gap - gap / 2 - 1) @(posedge clock);
    endtask : pulse
endmodule : sig_source

// ===== sim/test_dual_input_frequency_time_tagger.sv
// bench: self-checking register-level test of the dual input tagger
// assumes sig_source on the pins; tag buffer shortened to 8 entries
`timescale 1ns/1ns
module test_dual_input_frequency_time_tagger;
    localparam int DEPTH = 8;
    // shortened millisecond so the least timeout is 65540 cycles
    localparam int CYC_MS = 6554;
    localparam int TMO = int'(tagger_pkg::TMO_MIN_MS) * CYC_MS;
    logic clock;
    logic reset_n;
    logic cyc_i;
    logic stb_i;
    logic we_i;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic [1:0] sig_in;
    logic [31:0] rd;
    int err_count = 0;
    int total_checks = 0;
    int seed = 59861;
    int cyc_n = 0;
    int t0;
    int r;
    int gaps[10];

    sig_source src (.clock(clock), .pins(sig_in));
    freq_time_tagger #(.DEPTH(DEPTH), .CYC_MS(CYC_MS)) dut (
        .clock(clock), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .sig_in(sig_in), .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic [7:0] ca(input int ch, input logic [7:0] off);
        return 8'(ch) * tagger_pkg::CH_STRIDE + off;
    endfunction : ca

    // register view of a time in milliseconds: cycles over 65536
    function automatic logic [31:0] cyc16(input longint ms);
        return 32'((ms * CYC_MS) >> 16);
    endfunction : cyc16

    // one classic cycle; read data lands in rd
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        @(posedge clock);
        while (ack_o !== 1'b1) @(posedge clock);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        check(n, rd & m, e);
    endtask : rchk

    task automatic poll(input logic [7:0] a, input int lim);
        for (int i = 0; i < lim; i++) begin
            wb(1'b0, a, 32'h0, 4'hf);
            if (rd !== 32'h0) break;
        end
    endtask : poll

    // pops n tags; stamp spacing must match the pulse gaps from base
    task automatic pop_chk(input int n, input int base);
        logic [31:0] prev;
        prev = 32'h0;
        for (int i = 0; i < n; i++) begin
            wb(1'b0, tagger_pkg::OFF_TAG, 32'h0, 4'hf);
            if (i > 0) check("tag gap", rd - prev, gaps[base + i - 1]);
            prev = rd;
        end
    endtask : pop_chk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) cyc_n <= cyc_n + 1;

    initial begin
        #1_000_000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        for (int i = 0; i < 10; i++) gaps[i] = 24 + ($random(seed) & 63);
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rchk("falling0", ca(0, tagger_pkg::OFF_CTRL), 32'h101, 32'h0);
        rchk("count0", ca(0, tagger_pkg::OFF_COUNT), '1, 32'h1);
        rchk("policy", tagger_pkg::OFF_GLOBAL, 32'h1, 32'h1);
        wr(8'h60, 32'hffff_ffff);
        rchk("unmapped", 8'h60, '1, 32'h0);
        wb(1'b1, tagger_pkg::OFF_GLOBAL, 32'h0, 4'h1);
        rchk("policy sel", tagger_pkg::OFF_GLOBAL, 32'h1, 32'h1);
        r = ($random(seed) & 32'h1fff_ffff) + 1;
        wr(ca(1, tagger_pkg::OFF_COUNT), r);
        rchk("count1", ca(1, tagger_pkg::OFF_COUNT), '1, r);
        rchk("count0 kept", ca(0, tagger_pkg::OFF_COUNT), '1, 32'h1);
        wr(ca(1, tagger_pkg::OFF_COUNT), 32'(tagger_pkg::COUNT_MAX));
        rchk("count max", ca(1, tagger_pkg::OFF_COUNT), '1,
             32'(tagger_pkg::COUNT_MAX));
        wr(ca(1, tagger_pkg::OFF_COUNT), 32'h1);
        // front: two samples, huge gate, least timeout; rear: least both
        wr(ca(0, tagger_pkg::OFF_COUNT), 32'h2);
        wr(ca(0, tagger_pkg::OFF_GATE), 32'hffff_ffff);
        wr(ca(0, tagger_pkg::OFF_TMO), 32'h0);
        wr(ca(1, tagger_pkg::OFF_GATE), 32'h0);
        wr(ca(1, tagger_pkg::OFF_TMO), 32'h0);
        wr(ca(0, tagger_pkg::OFF_CTRL), 32'h3);
        wr(ca(1, tagger_pkg::OFF_CTRL), 32'h2);
        wr(tagger_pkg::OFF_GLOBAL, 32'h0);
        src.set_pin(0, 1'b0);
        t0 = cyc_n;
        src.set_pin(0, 1'b1);
        repeat (8) @(posedge clock);
        rchk("falling only", tagger_pkg::OFF_LEVEL, '1, 32'h1);
        wb(1'b0, tagger_pkg::OFF_TAG, 32'h0, 4'hf);
        // keep_oldest overflow, then refill freed space
        for (int i = 0; i < 10; i++) src.pulse(1, gaps[i]);
        rchk("level full", tagger_pkg::OFF_LEVEL, '1, DEPTH);
        pop_chk(8, 0);
        rchk("level empty", tagger_pkg::OFF_LEVEL, '1, 32'h0);
        rchk("drop flag", tagger_pkg::OFF_IRQ_STAT, 32'h10, 32'h10);
        check("irq masked", irq_o, 32'h0);
        wr(tagger_pkg::OFF_IRQ_MASK, 32'h10);
        repeat (2) @(posedge clock);
        check("irq on", irq_o, 32'h1);
        wr(tagger_pkg::OFF_IRQ_STAT, 32'h10);
        repeat (2) @(posedge clock);
        check("irq off", irq_o, 32'h0);
        for (int i = 0; i < 3; i++) src.pulse(1, gaps[i]);
        rchk("level refill", tagger_pkg::OFF_LEVEL, '1, 32'h3);
        pop_chk(3, 0);
        wr(tagger_pkg::OFF_GLOBAL, 32'h1);
        for (int i = 0; i < 10; i++) src.pulse(1, gaps[i]);
        rchk("level newest", tagger_pkg::OFF_LEVEL, '1, DEPTH);
        pop_chk(8, 2);
        // front times out from its lone edge; rear ends on its gate
        while (cyc_n < t0 + TMO - 5000) @(posedge clock);
        rchk("early done0", ca(0, tagger_pkg::OFF_DONE), '1, 32'h0);
        rchk("early done1", ca(1, tagger_pkg::OFF_DONE), '1, 32'h0);
        poll(ca(0, tagger_pkg::OFF_DONE), 2000);
        check("done0", rd, 32'h1);
        rchk("nan", ca(0, tagger_pkg::OFF_RESULT), '1,
             tagger_pkg::NAN_VALUE);
        rchk("busy0", ca(0, tagger_pkg::OFF_CTRL), 32'h100, 32'h100);
        rchk("tmo flag", tagger_pkg::OFF_IRQ_STAT, 32'h4, 32'h4);
        poll(ca(1, tagger_pkg::OFF_DONE), 2000);
        check("done1", rd, 32'h1);
        wb(1'b0, ca(1, tagger_pkg::OFF_RESULT), 32'h0, 4'hf);
        check("edges1", 32'(rd === 32'd23 || rd === 32'd22), 32'h1);
        rchk("busy1", ca(1, tagger_pkg::OFF_CTRL), 32'h100, 32'h0);
        rchk("done flag", tagger_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
        // defaults win over the falling bit written alongside
        wr(ca(0, tagger_pkg::OFF_CTRL), 32'h5);
        rchk("dflt edge", ca(0, tagger_pkg::OFF_CTRL), 32'h1, 32'h0);
        rchk("dflt count", ca(0, tagger_pkg::OFF_COUNT), '1, 32'h1);
        rchk("dflt gate", ca(0, tagger_pkg::OFF_GATE), '1,
             cyc16(tagger_pkg::GATE_DEF_MS));
        rchk("dflt tmo", ca(0, tagger_pkg::OFF_TMO), '1,
             cyc16(tagger_pkg::TMO_DEF_MS));
        wr(tagger_pkg::OFF_GLOBAL, 32'h0);
        wr(tagger_pkg::OFF_GLOBAL, 32'h4);
        rchk("dflt policy", tagger_pkg::OFF_GLOBAL, 32'h1, 32'h1);
        tally_and_finish();
    end
endmodule : test_dual_input_frequency_time_tagger
